// File: radio_aux_defs.svh
// Offsets, field positions, timing constants and response codes of the radio packet aux engine.
// Assumes a 50 MHz system clock and a 32-bit register bus.
`ifndef RADIO_AUX_DEFS_SVH
`define RADIO_AUX_DEFS_SVH
`define OFS_TRANSMIT_ENABLE_TASK      12'h000
`define OFS_RECEIVE_ENABLE_TASK      12'h004
`define OFS_START     12'h008
`define OFS_STOP      12'h00c
`define OFS_DISABLE   12'h010
`define OFS_RSSISTRT  12'h014
`define OFS_BCSTRT    12'h01c
`define OFS_BCSTP     12'h020
`define OFS_EVT_BASE  12'h10c
`define OFS_EVT_LAST  12'h128
`define OFS_SHORTCUTS 12'h200
`define OFS_MATCH_IDX 12'h410
`define OFS_PKTPTR    12'h504
`define OFS_MODE      12'h510
`define OFS_PKTCFG0   12'h514
`define OFS_PKTCFG1   12'h518
`define OFS_IFS       12'h544
`define OFS_RSSIVAL   12'h548
`define OFS_BCCMP     12'h560
`define OFS_ADDRLO    12'h600
`define OFS_ADDRHI    12'h620
`define OFS_MATCHCFG  12'h640
// Event slots (byte offset from event base is 4 per slot)
`define EV_END        3'd0
`define EV_DISABLED   3'd1
`define EV_DEVMATCH   3'd2
`define EV_DEVMISS    3'd3
`define EV_RSSIEND    3'd4
`define EV_BCHIT      3'd7
// Shortcut bits
`define SC_END_DIS    0
`define SC_DIS_TX     1
`define SC_DIS_RX     2
// Packet configuration fields
`define PC0_H1_LSB    0
`define PC0_LF_LSB    8
`define PC0_H2_LSB    16
`define PC1_MAX_LSB   0
`define PC1_STAT_LSB  8
`define PC1_ORDER_BIT 24
`define ADDR_TYPE_BIT 6
`define DEV_ADDR_BYTES 3'd6
// Timing and bus response codes
`define CLK_MHZ       50
`define TURNAROUND_US 150
`define US_CYCLES     (`CLK_MHZ)
`define RSSI_PERIOD_NS 1000
`define RSSI_CYCLES   ((`RSSI_PERIOD_NS * `CLK_MHZ) / 1000)
`define RESP_SLVERR   2'b10
`define RESP_OKAY     2'b00
`endif

// File: radio_aux_pkg.sv
// Types shared by the radio packet aux engine.
// Assumes the constants header is included where offsets are needed.
package radio_aux_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        write;
        logic        strobe;
    } mem_req_t;
    typedef struct packed {
        logic       byteStb;
        logic [7:0] byteIn;
        logic       bitStb;
        logic       lastBit;
        logic       txFirstBit;
    } link_in_t;
endpackage

// File: radio_packet_aux_engine.sv
// Packet aux engine: strength sampling, interframe hold, address match,
// bit counter and packet memory transfer. Assumes link strobes are synchronous.
// Functional notes
// - Strength filtered continuously by single-pole IIR
// - Start task samples; value readable after period
// - Enforce interframe interval unless below turnaround
// - Interval starts at last bit, ends first bit
// - Enforce only with end-disable plus disabled-enable shortcuts
// - Shortcuts direct; mode latched at enable tasks
// - Address match only receiving, little endian
// - First 48 payload bits address; bit6 type
// - Eight entries compared, each enabled, typed
// - Entry is low 32 plus high 16
// - Bit counter start/stop; hit on compare equal
// - Counter continues after hit; compare reloadable
// - Counter clears on stop, disable, end
// - One buffered pointer for both directions
// - Memory order header, length, header, payload
// - Fields rounded up to whole bytes
// - Payload plus add-on truncated to maximum
// - Checksum span uses truncated length
// - End event at last bit; disabled acknowledges
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`include "radio_aux_defs.svh"
module radio_packet_aux_engine
    import radio_aux_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `RSSI_CYCLES,
    parameter int ENTRIES       = 8
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite slave
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Link side
    input  wire link_in_t    link,
    input  wire logic [6:0]  strengthRaw,
    output logic             ifsHold,
    output logic [7:0]       txByte,
    output logic [3:0]       activeMode,
    output logic [8:0]       crcSpan,
    output logic             rxOn,
    output logic             txOn,
    output logic [7:0]       eventPulse,
    // Packet memory
    output mem_req_t         memReq,
    input  wire logic [7:0]  memRdata
);
    function automatic logic [4:0] fieldBytes(input logic [7:0] bits);
        fieldBytes = 5'((9'(bits) + 9'd7) >> 3);
    endfunction

    logic [31:0] shortcut_ff, pktPtr_ff, actPtr_ff, mode_ff, cfg0_ff, cfg1_ff;
    logic [31:0] ifs_ff, bcCmp_ff, bcCnt_ff;
    logic [31:0] addrLo_ff [ENTRIES];
    logic [15:0] addrHi_ff [ENTRIES];
    logic [15:0] matchCfg_ff;
    logic [7:0]  evt_ff, evtSet, evtClr;
    logic [9:0]  filt_ff;
    logic [6:0]  sample_ff;
    logic [15:0] rssiCnt_ff;
    logic        rssiBusy_ff;
    logic        bcRun_ff;
    logic [2:0]  matchIdx_ff;
    logic [15:0] usDiv_ff;
    logic [31:0] ifsCnt_ff;
    logic        disPend_ff, rxOn_ff, txOn_ff;
    logic [8:0]  idx_ff;
    logic [7:0]  len_ff;
    logic        addrType_ff, cmpPend_ff;
    logic [47:0] devAddr_ff;
    logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [11:0] wAddr;
    logic        wrFire, rdHit;
    logic [31:0] rdVal;
    mem_req_t    memReq_ff;
    logic [7:0]  txByte_ff, evtPulse_ff;
    logic [3:0]  actMode_ff;
    logic [8:0]  crcSpan_ff;
    logic        ifsHold_ff;

    // Task strobes
    logic tTxen, tRxen, tStart, tStop, tDis, tRssi, tBcStart, tBcStop;
    logic endEv, disEv, enforce, dataByte;
    logic [4:0] h1B, lfB, h2B;
    logic [8:0] hdrB, limit, pIdx, sumLen;
    logic [7:0] curByte;

    assign wAddr    = awaddr;
    assign wrFire   = awvalid && wvalid && !awready_ff && !bvalid_ff;
    assign tTxen    = wrFire && wAddr == `OFS_TRANSMIT_ENABLE_TASK && wdata[0];
    assign tRxen    = wrFire && wAddr == `OFS_RECEIVE_ENABLE_TASK && wdata[0];
    assign tStart   = wrFire && wAddr == `OFS_START && wdata[0];
    assign tStop    = wrFire && wAddr == `OFS_STOP && wdata[0];
    assign tDis     = wrFire && wAddr == `OFS_DISABLE && wdata[0];
    assign tRssi    = wrFire && wAddr == `OFS_RSSISTRT && wdata[0];
    assign tBcStart = wrFire && wAddr == `OFS_BCSTRT && wdata[0];
    assign tBcStop  = wrFire && wAddr == `OFS_BCSTP && wdata[0];

    assign endEv = link.lastBit;
    assign disEv = disPend_ff;

    // AXI write channel
    always_ff @(posedge clk) begin
        if (rst) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
        end else begin
            awready_ff <= wrFire;
            wready_ff  <= wrFire;
            if (wrFire) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (wAddr[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Configuration registers; shortcuts and interval act directly
    always_ff @(posedge clk) begin
        if (rst) begin
            shortcut_ff <= 32'h0;
            pktPtr_ff   <= 32'h0;
            mode_ff     <= 32'h0;
            cfg0_ff     <= 32'h0;
            cfg1_ff     <= 32'h0;
            ifs_ff      <= 32'h0;
            bcCmp_ff    <= 32'h0;
            matchCfg_ff <= 16'h0;
        end else if (wrFire && wstrb == 4'hf) begin
            case (wAddr)
                `OFS_SHORTCUTS: shortcut_ff <= wdata;
                `OFS_PKTPTR:    pktPtr_ff   <= wdata;
                `OFS_MODE:      mode_ff     <= wdata;
                `OFS_PKTCFG0:   cfg0_ff     <= wdata;
                `OFS_PKTCFG1:   cfg1_ff     <= wdata;
                `OFS_IFS:       ifs_ff      <= wdata;
                `OFS_BCCMP:     bcCmp_ff    <= wdata;
                `OFS_MATCHCFG:  matchCfg_ff <= wdata[15:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < ENTRIES; i++) begin
                addrLo_ff[i] <= 32'h0;
                addrHi_ff[i] <= 16'h0;
            end
        end else if (wrFire && wstrb == 4'hf) begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (wAddr == `OFS_ADDRLO + 12'(4 * i))
                    addrLo_ff[i] <= wdata;
                if (wAddr == `OFS_ADDRHI + 12'(4 * i))
                    addrHi_ff[i] <= wdata[15:0];
            end
        end
    end

    // Events: sticky, a write clears, a set in the same cycle wins
    always_comb begin
        evtClr = 8'h0;
        if (wrFire && wAddr >= `OFS_EVT_BASE && wAddr <= `OFS_EVT_LAST)
            evtClr[3'((wAddr - `OFS_EVT_BASE) >> 2)] = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            evt_ff      <= 8'h0;
            evtPulse_ff <= 8'h0;
        end else begin
            evt_ff      <= (evt_ff & ~evtClr) | evtSet;
            evtPulse_ff <= evtSet;
        end
    end

    // AXI read channel
    always_comb begin
        rdHit = 1'b1;
        rdVal = 32'h0;
        case (araddr)
            `OFS_SHORTCUTS: rdVal = shortcut_ff;
            `OFS_MATCH_IDX: rdVal = {29'h0, matchIdx_ff};
            `OFS_PKTPTR:    rdVal = pktPtr_ff;
            `OFS_MODE:      rdVal = mode_ff;
            `OFS_PKTCFG0:   rdVal = cfg0_ff;
            `OFS_PKTCFG1:   rdVal = cfg1_ff;
            `OFS_IFS:       rdVal = ifs_ff;
            `OFS_RSSIVAL:   rdVal = {25'h0, sample_ff};
            `OFS_BCCMP:     rdVal = bcCmp_ff;
            `OFS_MATCHCFG:  rdVal = {16'h0, matchCfg_ff};
            default: begin
                rdHit = 1'b0;
                for (int i = 0; i < ENTRIES; i++) begin
                    if (araddr == `OFS_ADDRLO + 12'(4 * i)) begin
                        rdHit = 1'b1;
                        rdVal = addrLo_ff[i];
                    end
                    if (araddr == `OFS_ADDRHI + 12'(4 * i)) begin
                        rdHit = 1'b1;
                        rdVal = {16'h0, addrHi_ff[i]};
                    end
                end
                if (araddr >= `OFS_EVT_BASE && araddr <= `OFS_EVT_LAST
                    && araddr[1:0] == 2'b00) begin
                    rdHit = 1'b1;
                    rdVal = {31'h0, evt_ff[3'((araddr - `OFS_EVT_BASE) >> 2)]};
                end
                if (araddr <= `OFS_BCSTP && araddr[1:0] == 2'b00)
                    rdHit = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0;
            rresp_ff   <= `RESP_OKAY;
        end else begin
            arready_ff <= arvalid && !arready_ff && !rvalid_ff;
            if (arvalid && !arready_ff && !rvalid_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rdVal;
                rresp_ff  <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Strength filter and sampler
    always_ff @(posedge clk) begin
        if (rst) begin
            filt_ff     <= 10'h0;
            sample_ff   <= 7'h0;
            rssiCnt_ff  <= 16'h0;
            rssiBusy_ff <= 1'b0;
        end else begin
            filt_ff <= filt_ff - (filt_ff >> 3) + {3'h0, strengthRaw};
            if (tRssi) begin
                rssiBusy_ff <= 1'b1;
                rssiCnt_ff  <= 16'h0;
            end else if (rssiBusy_ff) begin
                rssiCnt_ff <= rssiCnt_ff + 16'h1;
                if (rssiCnt_ff == 16'(SAMPLE_CYCLES - 1)) begin
                    rssiBusy_ff <= 1'b0;
                    sample_ff   <= filt_ff[9:3];
                end
            end
        end
    end

    // Radio enable state, mode latch and disable acknowledge
    always_ff @(posedge clk) begin
        if (rst) begin
            rxOn_ff    <= 1'b0;
            txOn_ff    <= 1'b0;
            disPend_ff <= 1'b0;
            actMode_ff <= 4'h0;
        end else begin
            disPend_ff <= tDis || (endEv && shortcut_ff[`SC_END_DIS]);
            if (tTxen || tRxen)
                actMode_ff <= mode_ff[3:0];
            if (disEv) begin
                txOn_ff <= shortcut_ff[`SC_DIS_TX];
                rxOn_ff <= shortcut_ff[`SC_DIS_RX] && !shortcut_ff[`SC_DIS_TX];
                if (shortcut_ff[`SC_DIS_TX] || shortcut_ff[`SC_DIS_RX])
                    actMode_ff <= mode_ff[3:0];
            end else if (tTxen) begin
                txOn_ff <= 1'b1;
                rxOn_ff <= 1'b0;
            end else if (tRxen) begin
                rxOn_ff <= 1'b1;
                txOn_ff <= 1'b0;
            end
        end
    end

    // Interframe interval hold
    assign enforce = shortcut_ff[`SC_END_DIS] &&
                     (shortcut_ff[`SC_DIS_TX] || shortcut_ff[`SC_DIS_RX]) &&
                     ifs_ff >= 32'(`TURNAROUND_US);

    always_ff @(posedge clk) begin
        if (rst) begin
            ifsHold_ff <= 1'b0;
            ifsCnt_ff  <= 32'h0;
            usDiv_ff   <= 16'h0;
        end else if (link.lastBit && enforce) begin
            ifsHold_ff <= 1'b1;
            ifsCnt_ff  <= 32'h0;
            usDiv_ff   <= 16'h0;
        end else if (ifsHold_ff) begin
            usDiv_ff <= (usDiv_ff == 16'(`US_CYCLES - 1)) ? 16'h0 : usDiv_ff + 16'h1;
            if (usDiv_ff == 16'(`US_CYCLES - 1))
                ifsCnt_ff <= ifsCnt_ff + 32'h1;
            if (link.txFirstBit || ifsCnt_ff >= ifs_ff)
                ifsHold_ff <= 1'b0;
        end
    end

    // Bit counter
    always_ff @(posedge clk) begin
        if (rst) begin
            bcRun_ff <= 1'b0;
            bcCnt_ff <= 32'h0;
        end else if (tBcStop || tStop || tDis || endEv || disEv) begin
            bcRun_ff <= 1'b0;
            bcCnt_ff <= 32'h0;
        end else if (tBcStart) begin
            bcRun_ff <= 1'b1;
            bcCnt_ff <= 32'h0;
        end else if (bcRun_ff && link.bitStb) begin
            bcCnt_ff <= bcCnt_ff + 32'h1;
        end
    end

    // Packet layout in memory
    assign h1B     = fieldBytes(cfg0_ff[`PC0_H1_LSB +: 8]);
    assign lfB     = fieldBytes(cfg0_ff[`PC0_LF_LSB +: 8]);
    assign h2B     = fieldBytes(cfg0_ff[`PC0_H2_LSB +: 8]);
    assign hdrB    = 9'(h1B) + 9'(lfB) + 9'(h2B);
    assign pIdx    = idx_ff - hdrB;
    assign sumLen  = 9'(len_ff) + 9'(cfg1_ff[`PC1_STAT_LSB +: 8]);
    assign limit   = (sumLen > 9'(cfg1_ff[`PC1_MAX_LSB +: 8]))
                     ? 9'(cfg1_ff[`PC1_MAX_LSB +: 8]) : sumLen;
    assign dataByte = idx_ff < hdrB || pIdx < limit;
    assign curByte = txOn_ff ? memRdata : link.byteIn;

    always_ff @(posedge clk) begin
        if (rst) begin
            actPtr_ff  <= 32'h0;
            idx_ff     <= 9'h0;
            len_ff     <= 8'h0;
            memReq_ff  <= '0;
            txByte_ff  <= 8'h0;
            crcSpan_ff <= 9'h0;
        end else begin
            memReq_ff.strobe <= 1'b0;
            if (tStart) begin
                actPtr_ff <= pktPtr_ff;
                memReq_ff.addr <= pktPtr_ff;
                idx_ff    <= 9'h0;
                len_ff    <= 8'h0;
            end else if (link.byteStb) begin
                idx_ff <= idx_ff + 9'h1;
                if (lfB != 5'h0 && idx_ff == 9'(h1B))
                    len_ff <= curByte;
                if (dataByte) begin
                    memReq_ff.strobe <= 1'b1;
                    memReq_ff.write  <= rxOn_ff;
                    // Transmit fetches one byte ahead so read data stands at the strobe
                    memReq_ff.addr   <= actPtr_ff + 32'(idx_ff) + 32'(!rxOn_ff);
                    memReq_ff.wdata  <= link.byteIn;
                end
                if (txOn_ff)
                    txByte_ff <= dataByte ? memRdata : 8'h0;
            end
            crcSpan_ff <= hdrB + limit;
        end
    end

    // Device address capture and compare
    always_ff @(posedge clk) begin
        if (rst) begin
            devAddr_ff  <= 48'h0;
            addrType_ff <= 1'b0;
            cmpPend_ff  <= 1'b0;
        end else begin
            cmpPend_ff <= 1'b0;
            if (link.byteStb && rxOn_ff && cfg1_ff[`PC1_ORDER_BIT] == 1'b0) begin
                if (idx_ff == 9'h0)
                    addrType_ff <= link.byteIn[`ADDR_TYPE_BIT];
                if (idx_ff >= hdrB && pIdx < 9'(`DEV_ADDR_BYTES)) begin
                    devAddr_ff <= {link.byteIn, devAddr_ff[47:8]};
                    cmpPend_ff <= pIdx == 9'(`DEV_ADDR_BYTES - 3'd1);
                end
            end
        end
    end

    logic       anyMatch;
    logic [2:0] hitIdx;
    always_comb begin
        anyMatch = 1'b0;
        hitIdx   = 3'h0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (matchCfg_ff[i] && matchCfg_ff[8 + i] == addrType_ff &&
                devAddr_ff == {addrHi_ff[i], addrLo_ff[i]}) begin
                anyMatch = 1'b1;
                hitIdx   = 3'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            matchIdx_ff <= 3'h0;
        else if (cmpPend_ff && anyMatch)
            matchIdx_ff <= hitIdx;
    end

    always_comb begin
        evtSet = 8'h0;
        evtSet[`EV_END]      = endEv;
        evtSet[`EV_DISABLED] = disEv;
        evtSet[`EV_DEVMATCH] = cmpPend_ff && anyMatch;
        evtSet[`EV_DEVMISS]  = cmpPend_ff && !anyMatch;
        evtSet[`EV_RSSIEND]  = rssiBusy_ff && rssiCnt_ff == 16'(SAMPLE_CYCLES - 1);
        evtSet[`EV_BCHIT]    = bcRun_ff && link.bitStb &&
                               bcCnt_ff + 32'h1 == bcCmp_ff;
    end

    assign awready    = awready_ff;
    assign wready     = wready_ff;
    assign bvalid     = bvalid_ff;
    assign bresp      = bresp_ff;
    assign arready    = arready_ff;
    assign rvalid     = rvalid_ff;
    assign rdata      = rdata_ff;
    assign rresp      = rresp_ff;
    assign ifsHold    = ifsHold_ff;
    assign txByte     = txByte_ff;
    assign activeMode = actMode_ff;
    assign crcSpan    = crcSpan_ff;
    assign rxOn       = rxOn_ff;
    assign txOn       = txOn_ff;
    assign eventPulse = evtPulse_ff;
    assign memReq     = memReq_ff;
endmodule // radio_packet_aux_engine

// File: radio_aux_asserts.sv
// Port-level timing checks for the radio packet aux engine.
// Assumes it is bound into the engine and given its sample-period parameter.
`include "radio_aux_defs.svh"
module radio_aux_asserts
    import radio_aux_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `RSSI_CYCLES
) (
    // Clock, reset and bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [11:0] awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    // Link side
    input wire link_in_t    link,
    input wire logic        ifsHold,
    input wire logic [3:0]  activeMode,
    input wire logic        rxOn,
    input wire logic [7:0]  eventPulse
);
    localparam int DoneLo = SAMPLE_CYCLES;
    localparam int DoneHi = SAMPLE_CYCLES + 3;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence wrTaken;
        awvalid && wvalid && !awready && !bvalid;
    endsequence
    sequence taskHit(logic [11:0] ofs);
        wrTaken ##0 (awaddr == ofs && wdata[0]);
    endsequence
    AST_WR_ANSWER: assert property (wrTaken |=> bvalid && awready && wready)
        else $error("write unanswered");
    AST_RD_ANSWER: assert property (arvalid && !arready && !rvalid |=> rvalid && arready)
        else $error("read unanswered");
    AST_B_ONCE: assert property (bvalid && bready |=> !bvalid)
        else $error("bvalid held");
    AST_DISABLED_ACK: assert property (
        taskHit(`OFS_DISABLE) |-> ##[1:4] eventPulse[`EV_DISABLED])
        else $error("no disabled ack");
    AST_STRENGTH_DONE: assert property (
        taskHit(`OFS_RSSISTRT) |-> ##[DoneLo:DoneHi] eventPulse[`EV_RSSIEND])
        else $error("no strength done");
    AST_IFS_RELEASE: assert property (ifsHold && link.txFirstBit |=> !ifsHold)
        else $error("hold after first bit");
    AST_MODE_LATCH: assert property (!$stable(activeMode) |-> bvalid || $past(bvalid))
        else $error("mode changed untasked");
    AST_MATCH_RX: assert property (
        eventPulse[`EV_DEVMATCH] || eventPulse[`EV_DEVMISS] |-> rxOn || $past(rxOn))
        else $error("match outside rx");
    AST_HIT_BIT: assert property (
        $rose(eventPulse[`EV_BCHIT]) |-> $past(link.bitStb))
        else $error("hit without bit");
endmodule // radio_aux_asserts

// File: packet_ram_model.sv
// Byte-wide packet RAM on the packet memory port.
// Assumes the bench keeps packet pointers below 256.
module packet_ram_model
    import radio_aux_pkg::*;
(
    // Clock and request
    input  wire logic     clk,
    input  wire mem_req_t memReq,
    // Read data
    output logic [7:0]    memRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    int         writes = 0;
    // Unwritten bytes hold a pattern unlike any packet byte
    initial foreach (mem[i]) mem[i] = 8'(i * 37 + 5);
    assign memRdata = mem[memReq.addr[7:0]];
    always @(posedge clk) begin
        if (memReq.strobe && memReq.write) begin
            mem[memReq.addr[7:0]] <= memReq.wdata;
            writes <= writes + 1;
        end
    end
endmodule // packet_ram_model

// File: test_radio_packet_aux_engine.sv
// Self-checking bench for the radio packet aux engine.
// Assumes package, header, checker and RAM model are compiled first.
`include "radio_aux_defs.svh"
module test_radio_packet_aux_engine
    import radio_aux_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam link_in_t BitP  = '{bitStb: 1'b1, default: '0};
    localparam link_in_t LastP = '{lastBit: 1'b1, default: '0};
    localparam link_in_t FirstP = '{txFirstBit: 1'b1, default: '0};
    localparam link_in_t ByteP = '{byteStb: 1'b1, default: '0};
    logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, ty;
    logic        awready, wready, bvalid, arready, rvalid, ifsHold, rxOn, txOn;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rdVal, lo;
    logic [3:0]  wstrb, activeMode, mode;
    logic [1:0]  bresp, rresp, rs;
    logic [6:0]  strengthRaw;
    logic [7:0]  txByte, eventPulse, memRdata;
    logic [8:0]  crcSpan;
    logic [15:0] hi;
    logic [47:0] da;
    link_in_t    link;
    mem_req_t    memReq;
    int          fails = 0, compares = 0, hits = 0, seedVal, slot, n, w0, len;
    radio_packet_aux_engine #(.SAMPLE_CYCLES(4)) dut (.*);
    packet_ram_model ram (.*);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (eventPulse[`EV_BCHIT] === 1'b1) hits <= hits + 1;
    task automatic test_done;
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] span(input int l, input int mx);
        return 32'(2 + (l > mx ? mx : l));
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do @(posedge clk); while (bvalid !== 1'b1);
        rs = bresp;
        {awvalid, wvalid, bready} <= 3'b000;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge clk); while (rvalid !== 1'b1);
        rdVal = rdata;
        rs = rresp;
        {arvalid, rready} <= 2'b00;
    endtask
    task automatic pulse(input link_in_t v);
        @(posedge clk) link <= v;
        @(posedge clk) link <= '0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        test_done;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, link} = '0;
        wstrb = 4'hf;
        rst = 1'b1;
        seedVal = $urandom(32'h8d21);
        strengthRaw = 7'($urandom);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(12'h7f0);
        chk(rs, `RESP_SLVERR);
        wr(12'h202, 0);
        chk(rs, `RESP_SLVERR);
        mode = 4'($urandom_range(1, 15));
        wr(`OFS_MODE, mode);
        chk(activeMode, 0);
        wr(`OFS_RECEIVE_ENABLE_TASK, 1);
        chk(activeMode, mode);
        repeat (2000) @(posedge clk);
        wr(`OFS_RSSISTRT, 1);
        repeat (8) @(posedge clk);
        rd(`OFS_RSSIVAL);
        chk(rdVal, strengthRaw);
        rd(`OFS_EVT_BASE + 12'h010);
        chk(rdVal, 1);
        // Two packets: matching entry, then wrong type flag and truncated length
        slot = $urandom_range(0, 7);
        lo = $urandom;
        hi = 16'($urandom);
        ty = 1'($urandom);
        da = {hi, lo};
        wr(`OFS_ADDRLO + 12'(4 * slot), lo);
        wr(`OFS_ADDRHI + 12'(4 * slot), 32'(hi));
        wr(`OFS_MATCHCFG, (32'(ty) << (8 + slot)) | (32'h1 << slot));
        wr(`OFS_PKTCFG0, 32'h0000_0808);
        wr(`OFS_PKTCFG1, 32'h0000_0008);
        for (int p = 0; p < 2; p++) begin
            len = 6 + 4 * p;
            w0 = ram.writes;
            wr(`OFS_PKTPTR, 32'(p * 64));
            wr(`OFS_START, 1);
            pulse('{byteStb: 1'b1, byteIn: {1'b0, ty ^ p[0], 6'h00}, default: '0});
            pulse('{byteStb: 1'b1, byteIn: 8'(len), default: '0});
            for (int i = 0; i < len; i++) begin
                pulse('{byteStb: 1'b1, byteIn: i < 6 ? da[8 * i +: 8] : 8'($urandom),
                    default: '0});
            end
            pulse(LastP);
            chk(ifsHold, 0);
            chk(crcSpan, span(len, 8));
            chk(ram.writes - w0, span(len, 8));
            rd(`OFS_EVT_BASE + 12'h008);
            chk(rdVal, 32'(p == 0));
            rd(`OFS_EVT_BASE + 12'h00c);
            chk(rdVal, 32'(p == 1));
            rd(`OFS_EVT_BASE);
            chk(rdVal, 1);
            if (p == 0) begin
                rd(`OFS_MATCH_IDX);
                chk(rdVal, slot);
            end
            for (int j = 0; j < 4; j++) wr(`OFS_EVT_BASE + 12'(4 * j), 0);
        end
        chk(ram.mem[2], lo[7:0]);
        chk(ram.mem[7], hi[15:8]);
        wr(`OFS_BCCMP, 5);
        wr(`OFS_BCSTRT, 1);
        repeat (7) pulse(BitP);
        chk(hits, 1);
        wr(`OFS_EVT_BASE + 12'h01c, 0);
        wr(`OFS_BCCMP, 9);
        repeat (2) pulse(BitP);
        chk(hits, 2);
        wr(`OFS_EVT_BASE + 12'h01c, 0);
        wr(`OFS_BCSTP, 1);
        wr(`OFS_BCCMP, 1);
        repeat (3) pulse(BitP);
        chk(hits, 2);
        wr(`OFS_BCSTRT, 1);
        pulse(BitP);
        chk(hits, 3);
        wr(`OFS_SHORTCUTS, 32'h3);
        wr(`OFS_IFS, 32'd150);
        pulse(LastP);
        chk(ifsHold, 1);
        n = 4;
        while (ifsHold === 1'b1 && n < 9000) begin
            @(posedge clk);
            n++;
        end
        chk(n > 7440 && n < 7510, 1);
        pulse(LastP);
        repeat (100) @(posedge clk);
        chk(ifsHold, 1);
        pulse(FirstP);
        chk(ifsHold, 0);
        wr(`OFS_PKTPTR, 0);
        wr(`OFS_START, 1);
        repeat (2) pulse(ByteP);
        chk(txByte, 6);
        wr(`OFS_EVT_BASE + 12'h004, 0);
        wr(`OFS_DISABLE, 1);
        rd(`OFS_EVT_BASE + 12'h004);
        chk(rdVal, 1);
        test_done;
    end
endmodule // test_radio_packet_aux_engine
bind radio_packet_aux_engine radio_aux_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) asserts_i (
    .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .link(link), .ifsHold(ifsHold),
    .activeMode(activeMode), .rxOn(rxOn), .eventPulse(eventPulse));
